// file: rtl/sfbp_host.sv
// Host controller for the flash buffer read, write and buffer-program commands
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`include "sfbp_defines.svh"
module sfbp_host #(
  parameter logic [7:0] STAT_OPCODE = 8'hd7,
  parameter int RDY_BIT = 7,
  parameter int EPE_BIT = 5
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic flash_cs_n,
  output logic flash_sck,
  output logic flash_mosi,
  input wire logic flash_miso
);
  import sfbp_pkg::*;

  sfbp_shift_if sh_if ();

  sfbp_shifter #(.HALF(`SFBP_SCK_HALF)) u_shift (
    .clock(clock),
    .reset(reset),
    .bus(sh_if),
    .miso(flash_miso),
    .sck(flash_sck),
    .mosi(flash_mosi)
  );

  sfbp_state_t state_r, state_nxt;
  sfbp_cmd_t cmd_r, cmd_nxt;
  logic m264_r, m264_nxt, csn_r, csn_nxt, pend_r, pend_nxt, start_r, start_nxt;
  logic poll_r, poll_nxt, epe_r, epe_nxt, done_r, done_nxt;
  logic txv_r, txv_nxt, rxv_r, rxv_nxt, wait_r, wait_nxt;
  logic [9:0] page_r, page_nxt;
  logic [8:0] bfa_r, bfa_nxt;
  logic [15:0] len_r, len_nxt, cnt_r, cnt_nxt;
  logic [1:0] ab_r, ab_nxt;
  logic [3:0] gap_r, gap_nxt;
  logic [7:0] shtx_r, shtx_nxt, tx_r, tx_nxt, rx_r, rx_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [23:0] aw;
  logic acc, acc_wr, acc_rd, go, is_prog, is_read, has_data;

  // ----------------------------------------
  // Command encoding
  // ----------------------------------------
  function automatic logic [7:0] opcode(input sfbp_cmd_t c);
    case (c)
      SFBP_RD_FAST: return `SFBP_OP_RD_FAST;
      SFBP_RD_SLOW: return `SFBP_OP_RD_SLOW;
      SFBP_BUF_WR: return `SFBP_OP_BUF_WR;
      SFBP_PG_ERASE: return `SFBP_OP_PG_ERASE;
      SFBP_PG_NOERASE: return `SFBP_OP_PG_NOERASE;
      default: return `SFBP_OP_WR_ERASE;
    endcase
  endfunction

  function automatic logic [23:0] addr_word(input sfbp_cmd_t c, input logic m,
                                            input logic [9:0] pg, input logic [8:0] bf);
    case (c)
      SFBP_PG_ERASE, SFBP_PG_NOERASE: return m ? {5'h00, pg, 9'h000} : {6'h00, pg, 8'h00};
      SFBP_WR_ERASE: return m ? {5'h00, pg, bf} : {6'h00, pg, bf[7:0]};
      default: return m ? {15'h0000, bf} : {16'h0000, bf[7:0]};
    endcase
  endfunction

  assign aw = addr_word(cmd_r, m264_r, page_r, bfa_r);
  assign is_prog = (cmd_r == SFBP_PG_ERASE) || (cmd_r == SFBP_PG_NOERASE)
                   || (cmd_r == SFBP_WR_ERASE);
  assign is_read = (cmd_r == SFBP_RD_FAST) || (cmd_r == SFBP_RD_SLOW);
  assign has_data = is_read || (cmd_r == SFBP_BUF_WR) || (cmd_r == SFBP_WR_ERASE);

  // ----------------------------------------
  // Avalon slave, one wait state per access
  // ----------------------------------------
  assign acc = (avs_read || avs_write) && !wait_r;
  assign acc_wr = avs_write && !wait_r;
  assign acc_rd = avs_read && !wait_r;
  assign go = acc_wr && (avs_address == `SFBP_OFF_CTRL) && avs_writedata[`SFBP_CTRL_GO_BIT];

  always_comb begin
    wait_nxt = !((avs_read || avs_write) && wait_r);
    rd_nxt = rd_r;
    if ((avs_read || avs_write) && wait_r) begin
      case (avs_address)
        `SFBP_OFF_CTRL: rd_nxt = {23'h0, 1'b0, 4'h0, m264_r, cmd_r};
        `SFBP_OFF_ADDR: rd_nxt = {6'h00, page_r, 7'h00, bfa_r};
        `SFBP_OFF_LEN: rd_nxt = {16'h0000, len_r};
        `SFBP_OFF_DATA: rd_nxt = {24'h000000, rx_r};
        `SFBP_OFF_STAT: rd_nxt = {26'h0, done_r, epe_r, poll_r, txv_r, rxv_r,
                                  state_r != SFBP_IDLE};
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    m264_nxt = m264_r;
    page_nxt = page_r;
    bfa_nxt = bfa_r;
    len_nxt = len_r;
    cnt_nxt = cnt_r;
    ab_nxt = ab_r;
    gap_nxt = gap_r;
    csn_nxt = csn_r;
    pend_nxt = pend_r;
    start_nxt = 1'b0;
    shtx_nxt = shtx_r;
    poll_nxt = poll_r;
    epe_nxt = epe_r;
    done_nxt = done_r;
    tx_nxt = tx_r;
    txv_nxt = txv_r;
    rx_nxt = rx_r;
    rxv_nxt = rxv_r;
    if (acc_wr && state_r == SFBP_IDLE) begin
      case (avs_address)
        `SFBP_OFF_CTRL: begin
          cmd_nxt = sfbp_cmd_t'(avs_writedata[`SFBP_CTRL_CMD_LSB +: 3]);
          m264_nxt = avs_writedata[`SFBP_CTRL_M264_BIT];
        end
        `SFBP_OFF_ADDR: begin
          bfa_nxt = avs_writedata[`SFBP_ADDR_BFA_LSB +: 9];
          page_nxt = avs_writedata[`SFBP_ADDR_PAGE_LSB +: 10];
        end
        `SFBP_OFF_LEN: len_nxt = avs_writedata[15:0];
        default: ;
      endcase
    end
    if (acc_wr && avs_address == `SFBP_OFF_DATA) begin
      tx_nxt = avs_writedata[7:0];
      txv_nxt = 1'b1;
    end
    if (acc_rd && avs_address == `SFBP_OFF_DATA) begin
      rxv_nxt = 1'b0;
    end
    if (acc_wr && avs_address == `SFBP_OFF_STAT && avs_writedata[`SFBP_STAT_DONE_BIT]) begin
      done_nxt = 1'b0;
    end
    case (state_r)
      SFBP_IDLE: begin
        csn_nxt = 1'b1;
        if (go) begin
          // new command only while idle, i.e. after ready was seen
          cmd_nxt = sfbp_cmd_t'(avs_writedata[`SFBP_CTRL_CMD_LSB +: 3]);
          m264_nxt = avs_writedata[`SFBP_CTRL_M264_BIT];
          cnt_nxt = len_r;
          csn_nxt = 1'b0;
          poll_nxt = 1'b0;
          state_nxt = SFBP_OPC;
        end
      end
      SFBP_OPC, SFBP_POLL_OP: begin
        if (!pend_r) begin
          start_nxt = 1'b1;
          shtx_nxt = (state_r == SFBP_OPC) ? opcode(cmd_r) : STAT_OPCODE;
          pend_nxt = 1'b1;
        end else if (sh_if.done) begin
          pend_nxt = 1'b0;
          ab_nxt = 2'h0;
          state_nxt = (state_r == SFBP_OPC) ? SFBP_ADR : SFBP_POLL_RD;
        end
      end
      SFBP_ADR: begin
        if (!pend_r) begin
          start_nxt = 1'b1;
          shtx_nxt = (ab_r == 2'h0) ? aw[23:16] : (ab_r == 2'h1) ? aw[15:8] : aw[7:0];
          pend_nxt = 1'b1;
        end else if (sh_if.done) begin
          pend_nxt = 1'b0;
          ab_nxt = ab_r + 2'h1;
          if (ab_r == 2'h2) begin
            // dummy byte for the fast read only
            if (cmd_r == SFBP_RD_FAST) begin
              state_nxt = SFBP_DUMMY;
            end else begin
              state_nxt = (has_data && cnt_r != 16'h0000) ? SFBP_DATA : SFBP_END;
            end
          end
        end
      end
      SFBP_DUMMY: begin
        if (!pend_r) begin
          start_nxt = 1'b1;
          shtx_nxt = `SFBP_DUMMY_BYTE;
          pend_nxt = 1'b1;
        end else if (sh_if.done) begin
          pend_nxt = 1'b0;
          state_nxt = (cnt_r != 16'h0000) ? SFBP_DATA : SFBP_END;
        end
      end
      SFBP_DATA: begin
        // bytes stall on software, so chip select stays low across the pause
        if (!pend_r && (is_read ? !rxv_r : txv_r)) begin
          start_nxt = 1'b1;
          shtx_nxt = is_read ? `SFBP_DUMMY_BYTE : tx_r;
          txv_nxt = !is_read && acc_wr && avs_address == `SFBP_OFF_DATA;
          pend_nxt = 1'b1;
        end else if (pend_r && sh_if.done) begin
          pend_nxt = 1'b0;
          cnt_nxt = cnt_r - 16'h0001;
          if (is_read) begin
            rx_nxt = sh_if.rx;
            rxv_nxt = 1'b1;
          end
          if (cnt_r == 16'h0001) begin
            state_nxt = SFBP_END;
          end
        end
      end
      SFBP_POLL_RD: begin
        if (!pend_r) begin
          start_nxt = 1'b1;
          shtx_nxt = `SFBP_DUMMY_BYTE;
          pend_nxt = 1'b1;
        end else if (sh_if.done) begin
          pend_nxt = 1'b0;
          epe_nxt = sh_if.rx[EPE_BIT];
          poll_nxt = !sh_if.rx[RDY_BIT];
          state_nxt = SFBP_END;
        end
      end
      SFBP_END: begin
        // chip select rise ends the frame and, after a program command, starts programming
        csn_nxt = 1'b1;
        gap_nxt = gap_r + 4'h1;
        if (gap_r == `SFBP_CS_GAP) begin
          gap_nxt = 4'h0;
          if ((state_r == SFBP_END) && (is_prog && !poll_r && ab_r != 2'h0)) begin
            poll_nxt = 1'b1;
          end
          if (is_prog && (poll_r || ab_r != 2'h0)) begin
            // keep polling while the device reports busy
            ab_nxt = 2'h0;
            csn_nxt = !(poll_r || ab_r != 2'h0);
            state_nxt = (poll_r || ab_r != 2'h0) ? SFBP_POLL_OP : SFBP_IDLE;
            if (!poll_r && ab_r == 2'h0) begin
              done_nxt = 1'b1;
            end
          end else begin
            state_nxt = SFBP_IDLE;
            done_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = SFBP_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= SFBP_IDLE;
      cmd_r <= SFBP_RD_FAST;
      m264_r <= `SFBP_RST_M264;
      page_r <= 10'h000;
      bfa_r <= 9'h000;
      len_r <= 16'h0000;
      cnt_r <= 16'h0000;
      ab_r <= 2'h0;
      gap_r <= 4'h0;
      csn_r <= 1'b1;
      pend_r <= 1'b0;
      start_r <= 1'b0;
      shtx_r <= 8'h00;
      poll_r <= 1'b0;
      epe_r <= 1'b0;
      done_r <= 1'b0;
      tx_r <= 8'h00;
      txv_r <= 1'b0;
      rx_r <= 8'h00;
      rxv_r <= 1'b0;
      wait_r <= 1'b1;
      rd_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      m264_r <= m264_nxt;
      page_r <= page_nxt;
      bfa_r <= bfa_nxt;
      len_r <= len_nxt;
      cnt_r <= cnt_nxt;
      ab_r <= ab_nxt;
      gap_r <= gap_nxt;
      csn_r <= csn_nxt;
      pend_r <= pend_nxt;
      start_r <= start_nxt;
      shtx_r <= shtx_nxt;
      poll_r <= poll_nxt;
      epe_r <= epe_nxt;
      done_r <= done_nxt;
      tx_r <= tx_nxt;
      txv_r <= txv_nxt;
      rx_r <= rx_nxt;
      rxv_r <= rxv_nxt;
      wait_r <= wait_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign sh_if.start = start_r;
  assign sh_if.tx = shtx_r;
  assign flash_cs_n = csn_r;
  assign avs_readdata = rd_r;
  assign avs_waitrequest = wait_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_prog_end;
    state_r == SFBP_END && is_prog && ab_r == 2'h3 && !poll_r && gap_r == `SFBP_CS_GAP;
  endsequence

  a_cs_in_frame: assert property (sh_if.busy |-> !csn_r)
    else $error("chip select high during a byte");
  a_fast_opcode: assert property (state_r == SFBP_OPC && start_r && cmd_r == SFBP_RD_FAST
    |-> shtx_r == 8'hd4)
    else $error("fast read opcode wrong");
  a_slow_opcode: assert property (state_r == SFBP_OPC && start_r && cmd_r == SFBP_RD_SLOW
    |-> shtx_r == 8'hd1)
    else $error("slow read opcode wrong");
  a_buf_addr_264: assert property (state_r == SFBP_ADR && (is_read || cmd_r == SFBP_BUF_WR)
    && m264_r |-> aw[23:9] == 15'h0000 && aw[8:0] == bfa_r)
    else $error("264 buffer address wrong");
  a_buf_addr_256: assert property (state_r == SFBP_ADR && (is_read || cmd_r == SFBP_BUF_WR)
    && !m264_r |-> aw[23:8] == 16'h0000 && aw[7:0] == bfa_r[7:0])
    else $error("256 buffer address wrong");
  a_page_addr: assert property (state_r == SFBP_ADR && cmd_r == SFBP_PG_NOERASE
    |-> (m264_r ? aw[18:9] : aw[17:8]) == page_r)
    else $error("page field misplaced");
  a_dummy_fast: assert property (state_r == SFBP_ADR && ab_r == 2'h2 && pend_r && sh_if.done
    |=> (state_r == SFBP_DUMMY) == (cmd_r == SFBP_RD_FAST))
    else $error("dummy byte rule broken");
  a_poll_after: assert property (s_prog_end |=> state_r == SFBP_POLL_OP ##1 !csn_r)
    else $error("no status poll after program");
  a_busy_blocks: assert property (poll_r && state_r == SFBP_END |=> state_r != SFBP_IDLE
    [*2])
    else $error("left polling while busy");
  a_cs_rise_hold: assert property ($rose(csn_r) |-> csn_r [*6])
    else $error("chip select high too short");
endmodule

// file: pkg/sfbp_defines.svh
// Register map, opcodes, field positions and timing counts of the buffer-program host
`ifndef SFBP_DEFINES_SVH
`define SFBP_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SFBP_OFF_CTRL 5'h00
`define SFBP_OFF_ADDR 5'h04
`define SFBP_OFF_LEN 5'h08
`define SFBP_OFF_DATA 5'h0c
`define SFBP_OFF_STAT 5'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SFBP_CTRL_CMD_LSB 0
`define SFBP_CTRL_M264_BIT 3
`define SFBP_CTRL_GO_BIT 8
`define SFBP_ADDR_BFA_LSB 0
`define SFBP_ADDR_PAGE_LSB 16
`define SFBP_STAT_ACTIVE_BIT 0
`define SFBP_STAT_RXV_BIT 1
`define SFBP_STAT_TXF_BIT 2
`define SFBP_STAT_POLL_BIT 3
`define SFBP_STAT_EPE_BIT 4
`define SFBP_STAT_DONE_BIT 5
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFBP_OP_RD_FAST 8'hd4
`define SFBP_OP_RD_SLOW 8'hd1
`define SFBP_OP_BUF_WR 8'h84
`define SFBP_OP_PG_ERASE 8'h83
`define SFBP_OP_PG_NOERASE 8'h88
`define SFBP_OP_WR_ERASE 8'h82
`define SFBP_DUMMY_BYTE 8'h00
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define SFBP_RST_M264 1'b0
`define SFBP_SCK_HALF 4
`define SFBP_CS_GAP 4'h6
`endif

// file: pkg/sfbp_pkg.sv
// Types shared by the buffer-program host modules
package sfbp_pkg;
  typedef enum logic [2:0] {
    SFBP_RD_FAST,
    SFBP_RD_SLOW,
    SFBP_BUF_WR,
    SFBP_PG_ERASE,
    SFBP_PG_NOERASE,
    SFBP_WR_ERASE
  } sfbp_cmd_t;

  typedef enum {
    SFBP_IDLE,
    SFBP_OPC,
    SFBP_ADR,
    SFBP_DUMMY,
    SFBP_DATA,
    SFBP_END,
    SFBP_POLL_OP,
    SFBP_POLL_RD
  } sfbp_state_t;
endpackage

// file: pkg/sfbp_shift_if.sv
// Byte handshake between the command sequencer and the serial shifter
`timescale 1ns/1ns
interface sfbp_shift_if;
  logic start;
  logic [7:0] tx;
  logic [7:0] rx;
  logic done;
  logic busy;
  modport ctrl (output start, output tx, input rx, input done, input busy);
  modport shift (input start, input tx, output rx, output done, output busy);
endinterface

// file: rtl/sfbp_shifter.sv
// Mode-0 serial byte shifter that makes the link clock by division
`timescale 1ns/1ns
`include "sfbp_defines.svh"
module sfbp_shifter #(
  parameter int HALF = `SFBP_SCK_HALF
) (
  input wire logic clock,
  input wire logic reset,
  sfbp_shift_if.shift bus,
  input wire logic miso,
  output logic sck,
  output logic mosi
);
  import sfbp_pkg::*;
  logic m1_r, m2_r;
  logic busy_r, busy_nxt, sck_r, sck_nxt, mosi_r, mosi_nxt, done_r, done_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] div_r, div_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    busy_nxt = busy_r;
    sck_nxt = sck_r;
    mosi_nxt = mosi_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    div_nxt = div_r;
    done_nxt = 1'b0;
    if (!busy_r) begin
      if (bus.start) begin
        busy_nxt = 1'b1;
        sh_nxt = bus.tx;
        mosi_nxt = bus.tx[7];
        bit_nxt = 3'h0;
        div_nxt = 8'h00;
      end
    end else if (div_r == 8'(HALF - 1)) begin
      div_nxt = 8'h00;
      if (!sck_r) begin
        sck_nxt = 1'b1;
      end else begin
        // Sample late in the high phase so the synchroniser delay is covered
        sck_nxt = 1'b0;
        sh_nxt = {sh_r[6:0], m2_r};
        if (bit_r == 3'h7) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end else begin
          bit_nxt = bit_r + 3'h1;
          mosi_nxt = sh_r[6];
        end
      end
    end else begin
      div_nxt = div_r + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      m1_r <= 1'b0;
      m2_r <= 1'b0;
      busy_r <= 1'b0;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      div_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      m1_r <= miso;
      m2_r <= m1_r;
      busy_r <= busy_nxt;
      sck_r <= sck_nxt;
      mosi_r <= mosi_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      div_r <= div_nxt;
      done_r <= done_nxt;
    end
  end

  assign bus.busy = busy_r;
  assign bus.done = done_r;
  assign bus.rx = sh_r;
  assign sck = sck_r;
  assign mosi = mosi_r;
endmodule

// file: dv/sfbp_flash_model.sv
// Behavioural serial flash: page buffer, buffer-program commands, status polling
`timescale 1ns/1ns
module sfbp_flash_model #(
  parameter int BUSY_POLLS = 2,
  parameter int RDY_BIT = 7,
  parameter int EPE_BIT = 5,
  parameter logic [7:0] STAT_OP = 8'hd7
) (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic m264,
  input wire logic fail_next,
  output logic miso
);
  logic [7:0] buffer_mem [0:263];
  logic [7:0] opc = 8'h00, rx_sr, tx_sr = 8'h00, last_op;
  logic [23:0] addr_r, last_addr;
  logic so_r = 1'b0, drive = 1'b0, erase_program_error_flag = 1'b0;
  int bitc, nbyte, frame_bytes, busy_cnt, poll_cnt, ptr;
  // one dummy byte for the fast read only
  function automatic int dstart();
    return (opc == 8'hd4) ? 5 : 4;
  endfunction
  // buffer wraps at its mode size
  function automatic int wrap(input int p);
    return (p + 1) % (m264 ? 264 : 256);
  endfunction
  // released line shows inverse of last bit
  assign miso = drive ? so_r : ~so_r;
  always @(negedge cs_n) begin
    bitc = 0;
    nbyte = 0;
  end
  always @(posedge sck) begin
    if (!cs_n) begin
      rx_sr = {rx_sr[6:0], mosi};
      bitc++;
      if (bitc == 8) begin
        bitc = 0;
        if (nbyte == 0) opc = rx_sr;
        else if (nbyte < 4) addr_r = {addr_r[15:0], rx_sr};
        if (nbyte == 3) ptr = m264 ? int'(addr_r[8:0]) : int'(addr_r[7:0]);
        else if (nbyte >= dstart() && (opc == 8'h84 || opc == 8'h82)) begin
          buffer_mem[ptr] = rx_sr;
          ptr = wrap(ptr);
        end
        nbyte++;
      end
    end
  end
  // both read opcodes stream the buffer
  always @(negedge sck) begin
    if (!cs_n) begin
      if (bitc == 0 && opc == STAT_OP && nbyte >= 1) begin
        tx_sr = 8'h00;
        tx_sr[RDY_BIT] = (busy_cnt == 0);
        tx_sr[EPE_BIT] = erase_program_error_flag;
        drive = 1'b1;
      end else if (bitc == 0 && (opc == 8'hd4 || opc == 8'hd1) && nbyte >= dstart()) begin
        tx_sr = buffer_mem[ptr];
        ptr = wrap(ptr);
        drive = 1'b1;
      end
      so_r = tx_sr[7];
      tx_sr = tx_sr << 1;
    end
  end
  always @(posedge cs_n) begin
    drive = 1'b0;
    if (opc == STAT_OP) begin
      poll_cnt++;
      if (busy_cnt > 0) busy_cnt--;
    end else begin
      frame_bytes = nbyte;
      last_op = opc;
      last_addr = addr_r;
      if ((opc == 8'h83 || opc == 8'h88 || opc == 8'h82) && bitc == 0) begin
        busy_cnt = BUSY_POLLS;
        poll_cnt = 0;
        erase_program_error_flag = fail_next;
      end
    end
  end
endmodule

// file: dv/spi_flash_buffer_program_test.sv
// Self-checking bench for the buffer-program host over Avalon-MM
`timescale 1ns/1ns
`include "sfbp_defines.svh"
module spi_flash_buffer_program_test;
  logic clock, reset, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, s;
  logic flash_cs_n, flash_sck, flash_mosi, flash_miso, mode_264, fail_next;
  logic [9:0] pg;
  logic [8:0] bf;
  logic [23:0] ea;
  logic [7:0] ops [0:2] = '{8'h83, 8'h88, 8'h82};
  int err_count, comparisons, cyc, i, m, c;
  sfbp_host uut (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_cs_n(flash_cs_n), .flash_sck(flash_sck), .flash_mosi(flash_mosi),
    .flash_miso(flash_miso));
  sfbp_flash_model flash (.cs_n(flash_cs_n), .sck(flash_sck), .mosi(flash_mosi),
    .m264(mode_264), .fail_next(fail_next), .miso(flash_miso));
  always #10 clock = ~clock;
  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waitrequest and read data are taken at the rising edge, before that edge updates them
  task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_write <= 1'b0;
  endtask
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    av_rd(`SFBP_OFF_STAT, s);
    while (s[b] !== v && n < 4000) begin
      av_rd(`SFBP_OFF_STAT, s);
      n++;
    end
    check("status bit", v, s[b]);
  endtask
  task automatic run(input int cmd, input logic md, input logic [9:0] p, input logic [8:0] b,
    input logic [15:0] len);
    mode_264 <= md;
    av_wr(`SFBP_OFF_ADDR, {6'h0, p, 7'h0, b});
    av_wr(`SFBP_OFF_LEN, {16'h0, len});
    av_wr(`SFBP_OFF_CTRL, {23'h0, 1'b1, 4'h0, md, 3'(cmd)});
  endtask
  task automatic send(input logic [7:0] b);
    wait_stat(`SFBP_STAT_TXF_BIT, 1'b0);
    av_wr(`SFBP_OFF_DATA, {24'h0, b});
  endtask
  task automatic recv(input logic [7:0] e);
    wait_stat(`SFBP_STAT_RXV_BIT, 1'b1);
    av_rd(`SFBP_OFF_DATA, s);
    check("rx byte", e, s[7:0]);
  endtask
  task automatic finish_op();
    wait_stat(`SFBP_STAT_DONE_BIT, 1'b1);
    av_rd(`SFBP_OFF_STAT, s);
    av_wr(`SFBP_OFF_STAT, 32'h20);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Ceiling is several times the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    mode_264 = 1'b0;
    fail_next = 1'b0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    check("cs idle", 1'b1, flash_cs_n);
    check("sck idle", 1'b0, flash_sck);
    av_rd(`SFBP_OFF_STAT, s);
    check("stat reset", 32'h0, s);
    av_rd(5'h14, s);
    check("unmapped", 32'h0, s);
    $display("test reset done");
    run(2, 1'b0, 10'h3ff, 9'h0fe, 16'h4);
    for (i = 0; i < 4; i++) send(8'ha1 + 8'(i));
    finish_op();
    for (i = 0; i < 4; i++) begin
      check("buffer", 8'ha1 + 8'(i), flash.buffer_mem[(254 + i) % 256]);
    end
    check("write addr", 24'h0000fe, flash.last_addr);
    check("write frame", 8, flash.frame_bytes);
    $display("test write 256 done");
    for (c = 0; c < 2; c++) begin
      run(c, 1'b0, 10'h0, 9'h0ff, 16'h3);
      for (i = 0; i < 3; i++) recv(8'ha2 + 8'(i));
      finish_op();
      check("read opcode", c ? 8'hd1 : 8'hd4, flash.last_op);
      check("read frame", c ? 7 : 8, flash.frame_bytes);
      check("read addr", 24'h0000ff, flash.last_addr);
    end
    $display("test read 256 done");
    run(2, 1'b1, 10'h0, 9'h107, 16'h2);
    send(8'hb1);
    send(8'hb2);
    finish_op();
    check("buffer end", 8'hb1, flash.buffer_mem[263]);
    check("buffer wrap", 8'hb2, flash.buffer_mem[0]);
    check("write addr", 24'h000107, flash.last_addr);
    run(1, 1'b1, 10'h0, 9'h107, 16'h2);
    recv(8'hb1);
    recv(8'hb2);
    finish_op();
    check("read addr", 24'h000107, flash.last_addr);
    $display("test 264 mode done");
    for (i = 0; i < 6; i++) begin
      c = i / 2;
      m = i % 2;
      pg = 10'h2a5 ^ 10'(i);
      bf = (c == 2) ? 9'h0c3 : 9'h0;
      fail_next <= (i == 3);
      run(c + 3, m[0], pg, bf, (c == 2) ? 16'h1 : 16'h0);
      if (c == 2) send(8'h5a + 8'(i));
      finish_op();
      check("prog opcode", ops[c], flash.last_op);
      ea = m ? {5'h0, pg, bf} : {6'h0, pg, bf[7:0]};
      check("prog addr", ea, flash.last_addr);
      check("prog frame", (c == 2) ? 5 : 4, flash.frame_bytes);
      check("poll count", 3, flash.poll_cnt);
      check("error flag", i == 3, s[`SFBP_STAT_EPE_BIT]);
      check("active", 1'b0, s[`SFBP_STAT_ACTIVE_BIT]);
      if (c == 2) check("prog load", 8'h5a + 8'(i), flash.buffer_mem[bf]);
    end
    $display("test program done");
    give_verdict();
  end
endmodule
